// File: rtl/srh_defines.svh
// register offsets, field positions and reset values of the soft reset block
// Functional notes
// - bit 19 set holds fabric port b in reset; clear releases it.
// - bit 18 set holds fabric port a in reset; clear releases it.
// - bit 17 set holds the fast dma in reset; clear releases it.
// - bit 16 set asserts the active-low fabric reset output.
// - bit 15 set holds the comm unit in reset; clear releases it.
// - bit 9 set holds the serial port in reset; clear releases it.
// - bit 5 set holds the peripheral dma in reset; clear releases it.
// - bits 3 and 2 hold sram controller b and a in reset.
// - bits 1 and 0 hold flash controller b and a in reset.
// - bits 14:10, 8:6 and 4 always read and act as one.
// - register is read-write, reset by system reset, bitwise write lock.
`ifndef SRH_DEFINES_SVH
`define SRH_DEFINES_SVH

`define SRH_HOLD_OFFSET   12'h000
`define SRH_LOCK_OFFSET   12'h004
`define SRH_STAT_OFFSET   12'h008

`define SRH_BIT_FAB_B     19
`define SRH_BIT_FAB_A     18
`define SRH_BIT_FAST_DMA  17
`define SRH_BIT_FABRIC    16
`define SRH_BIT_COMM      15
`define SRH_BIT_SPI       9
`define SRH_BIT_PERIPH_DMA      5
`define SRH_BIT_SRAM_B    3
`define SRH_BIT_SRAM_A    2
`define SRH_BIT_FLASH_B   1
`define SRH_BIT_FLASH_A   0

`define SRH_IMPL_MASK     32'h000F822F
`define SRH_FORCED_MASK   32'h00007DD0
`define SRH_HOLD_RESET    32'h000FFFFF
`define SRH_LOCK_RESET    32'h00000000

`endif

// File: rtl/srh_pkg.sv
// types shared by the soft reset block
package srh_pkg;
  typedef logic [31:0] srh_word_t;
  typedef logic [11:0] srh_addr_t;
  typedef enum logic [1:0] {
    SRH_SEL_HOLD,
    SRH_SEL_LOCK,
    SRH_SEL_STAT,
    SRH_SEL_NONE
  } srh_sel_t;
endpackage

// File: rtl/srh_soft_reset.sv
// soft reset control register with per-unit reset outputs over apb
//
// Our own choices: the register offsets and the APB interface to the registers.
`include "srh_defines.svh"
module srh_soft_reset (
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire srh_pkg::srh_addr_t paddr,
  input  wire srh_pkg::srh_word_t pwdata,
  output logic                 pready,
  output logic                 pslverr,
  output srh_pkg::srh_word_t   prdata,
  input  wire logic [10:0]     ext_reset_req,
  output logic                 fabric_port_b_rst,
  output logic                 fabric_port_a_rst,
  output logic                 fast_dma_rst,
  output logic                 fabric_reset_out_n,
  output logic                 comm_unit_rst,
  output logic                 serial_port_rst,
  output logic                 periph_dma_rst,
  output logic                 sram_ctrl_b_rst,
  output logic                 sram_ctrl_a_rst,
  output logic                 flash_ctrl_b_rst,
  output logic                 flash_ctrl_a_rst
);
  import srh_pkg::*;

  srh_word_t  hold_ff;
  srh_word_t  lock_ff;
  srh_word_t  nxt_hold;
  srh_word_t  nxt_lock;
  srh_word_t  rd_word;
  srh_sel_t   sel;
  logic [10:0] ext_meta_ff;
  logic [10:0] ext_sync_ff;
  logic [10:0] unit_hold;
  logic [10:0] unit_rst;
  logic [10:0] unit_rst_ff;
  logic       setup;
  logic       wr_fire;
  logic       rd_fire;

  function automatic srh_sel_t decode(input srh_addr_t a);
    if (a == `SRH_HOLD_OFFSET)
      return SRH_SEL_HOLD;
    else if (a == `SRH_LOCK_OFFSET)
      return SRH_SEL_LOCK;
    else if (a == `SRH_STAT_OFFSET)
      return SRH_SEL_STAT;
    else
      return SRH_SEL_NONE;
  endfunction

  // one wait-free access phase: answer comes in the first access cycle
  assign setup   = psel & ~penable;
  assign sel     = decode(paddr);
  assign wr_fire = psel & penable & pwrite;
  assign rd_fire = setup & ~pwrite;

  // locked bits keep their value; forced positions stay one
  assign nxt_hold = (wr_fire && sel == SRH_SEL_HOLD)
    ? (((pwdata & ~lock_ff) | (hold_ff & lock_ff)) & `SRH_IMPL_MASK)
      | `SRH_FORCED_MASK
    : hold_ff;
  // lock bits are sticky: once set only reset clears them
  assign nxt_lock = (wr_fire && sel == SRH_SEL_LOCK)
    ? lock_ff | (pwdata & `SRH_HOLD_RESET)
    : lock_ff;

  assign unit_hold = {hold_ff[`SRH_BIT_FAB_B],
                      hold_ff[`SRH_BIT_FAB_A],
                      hold_ff[`SRH_BIT_FAST_DMA],
                      hold_ff[`SRH_BIT_FABRIC],
                      hold_ff[`SRH_BIT_COMM],
                      hold_ff[`SRH_BIT_SPI],
                      hold_ff[`SRH_BIT_PERIPH_DMA],
                      hold_ff[`SRH_BIT_SRAM_B],
                      hold_ff[`SRH_BIT_SRAM_A],
                      hold_ff[`SRH_BIT_FLASH_B],
                      hold_ff[`SRH_BIT_FLASH_A]};
  assign unit_rst = unit_hold | ext_sync_ff;

  always_comb begin
    unique case (sel)
      SRH_SEL_HOLD: rd_word = hold_ff;
      SRH_SEL_LOCK: rd_word = lock_ff;
      SRH_SEL_STAT: rd_word = {21'h000000, unit_rst_ff};
      SRH_SEL_NONE: rd_word = 32'h00000000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_ff <= `SRH_HOLD_RESET;
      lock_ff <= `SRH_LOCK_RESET;
    end else begin
      hold_ff <= nxt_hold;
      lock_ff <= nxt_lock;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_meta_ff <= 11'h7FF;
      ext_sync_ff <= 11'h7FF;
    end else begin
      ext_meta_ff <= ext_reset_req;
      ext_sync_ff <= ext_meta_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_rst_ff <= 11'h7FF;
    end else begin
      unit_rst_ff <= unit_rst;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= setup;
      pslverr <= setup & (sel == SRH_SEL_NONE);
      prdata  <= rd_fire ? rd_word : 32'h00000000;
    end
  end

  // each unit reset output is its own flip-flop, same stage as status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fabric_port_b_rst <= 1'b1;
    end else begin
      fabric_port_b_rst <= unit_rst[10];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fabric_port_a_rst <= 1'b1;
    end else begin
      fabric_port_a_rst <= unit_rst[9];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_dma_rst <= 1'b1;
    end else begin
      fast_dma_rst <= unit_rst[8];
    end
  end

  // active low toward the fabric: low while held
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fabric_reset_out_n <= 1'b0;
    end else begin
      fabric_reset_out_n <= ~unit_rst[7];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comm_unit_rst <= 1'b1;
    end else begin
      comm_unit_rst <= unit_rst[6];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_port_rst <= 1'b1;
    end else begin
      serial_port_rst <= unit_rst[5];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_dma_rst <= 1'b1;
    end else begin
      periph_dma_rst <= unit_rst[4];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sram_ctrl_b_rst <= 1'b1;
    end else begin
      sram_ctrl_b_rst <= unit_rst[3];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sram_ctrl_a_rst <= 1'b1;
    end else begin
      sram_ctrl_a_rst <= unit_rst[2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_ctrl_b_rst <= 1'b1;
    end else begin
      flash_ctrl_b_rst <= unit_rst[1];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_ctrl_a_rst <= 1'b1;
    end else begin
      flash_ctrl_a_rst <= unit_rst[0];
    end
  end
endmodule

// File: verification/srh_soft_reset_properties.sv
// port assertions of the soft reset block
module srh_soft_reset_properties (
  input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire srh_pkg::srh_addr_t paddr,
  input wire srh_pkg::srh_word_t pwdata, prdata,
  input wire logic [10:0] ext_reset_req,
  input wire logic fabric_port_b_rst, fast_dma_rst, fabric_reset_out_n,
  input wire logic serial_port_rst, flash_ctrl_a_rst
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr = psel && penable && pwrite && paddr == 12'h000;
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready");
  a_ready_once: assert property (pready |=> !pready)
    else $error("ready held");
  a_err_zero: assert property (pslverr |-> pready && prdata == 0)
    else $error("bad error");
  a_forced_read: assert property (pready && !pwrite && !paddr |->
    (prdata & 32'hFFF07DD0) == 32'h00007DD0) else $error("forced bits");
  a_set_port_b: assert property (wr && pwdata[19] |-> ##2
    fabric_port_b_rst) else $error("port b free");
  a_set_fabric: assert property (wr && pwdata[16] |-> ##2
    !fabric_reset_out_n) else $error("fabric free");
  a_set_serial: assert property (wr && pwdata[9] |-> ##2
    serial_port_rst) else $error("serial free");
  a_ext_dma: assert property (ext_reset_req[8] [*4] |-> fast_dma_rst)
    else $error("dma free");
  a_ext_flash: assert property (ext_reset_req[0] [*4] |->
    flash_ctrl_a_rst) else $error("flash free");
  cover property (wr);
  cover property (pslverr);
  cover property (ext_reset_req[8] [*4]);
endmodule
bind srh_soft_reset srh_soft_reset_properties u_props (.*);

// File: verification/srh_soft_reset_tb_top.sv
// self-checking bench of the soft reset block
`include "srh_defines.svh"
module srh_soft_reset_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import srh_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [10:0] ext_reset_req = '0;
  srh_addr_t paddr = '0;
  srh_word_t pwdata = '0, rd, w;
  wire srh_word_t prdata;
  wire pready, pslverr, fabric_port_b_rst, fabric_port_a_rst, fast_dma_rst,
    fabric_reset_out_n, comm_unit_rst, serial_port_rst, periph_dma_rst,
    sram_ctrl_b_rst, sram_ctrl_a_rst, flash_ctrl_b_rst, flash_ctrl_a_rst;
  wire [10:0] units = {fabric_port_b_rst, fabric_port_a_rst, fast_dma_rst,
    ~fabric_reset_out_n, comm_unit_rst, serial_port_rst, periph_dma_rst,
    sram_ctrl_b_rst, sram_ctrl_a_rst, flash_ctrl_b_rst, flash_ctrl_a_rst};
  int fails = 0, comparisons = 0, seed = 82;
  srh_soft_reset u_srh_soft_reset (.*);
  initial forever #5 pclk = ~pclk;
  initial begin
    #100us;
    fails++;
    end_of_test();
  end
  task automatic chk(string what, srh_word_t seen, exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask
  // leaves psel high so a following call makes a back-to-back transfer
  task automatic apb(logic wt, srh_addr_t a, srh_word_t d);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wt, a, d};
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    {rd, err} = {prdata, pslverr};
    penable <= 0;
  endtask
  function automatic srh_word_t hold(srh_word_t v);
    return v & `SRH_IMPL_MASK | `SRH_FORCED_MASK;
  endfunction
  task automatic end_of_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    logic [10:0] x;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, 12'h000, 0);
    psel <= 0;
    chk("reset", rd, `SRH_HOLD_RESET);
    for (int i = 0; i < 24; i++) begin
      w = i == 0 ? 0 : i == 1 ? '1 : $random(seed);
      x = i % 3 == 2 ? 11'($random(seed)) : 11'h0;
      ext_reset_req <= x;
      apb(1, 12'h000, w);
      apb(0, 12'h000, 0);
      psel <= 0;
      chk("hold", rd, hold(w));
      repeat (4) @(posedge pclk);
      chk("units", 32'(units), 32'({w[19:15], w[9], w[5], w[3:0]} | x));
    end
    $display("test random done");
    ext_reset_req <= '0;
    apb(1, 12'h00C, 0);
    chk("unmapped", 32'(err), 32'h1);
    apb(1, 12'h000, '1);
    apb(1, 12'h004, 32'h00087DD0);
    apb(1, 12'h000, 0);
    apb(0, 12'h000, 0);
    chk("lock", rd, 32'h00087DD0);
    apb(0, 12'h004, 0);
    chk("lock read", rd, 32'h00087DD0);
    apb(0, 12'h008, 0);
    psel <= 0;
    chk("status", rd, 32'h00000400);
    repeat (2) @(posedge pclk);
    chk("units lock", 32'(units), 32'h00000400);
    $display("test lock done");
    end_of_test();
  end
endmodule
